/* design/frame_tracker.sv */
// Bookkeeping of on-chip local frames and frames spilled to memory
`include "regfile_consts.svh"
module frame_tracker #(
    parameter int NUM_FRAMES = `NUM_FRAMES,
    parameter int DEPTH_W = `DEPTH_W
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Frame changes, applied when the data move is finished
    input wire logic call_commit,
    input wire logic ret_commit,
    // Slot and depth state
    output logic [$clog2(NUM_FRAMES)-1:0] cur_slot,
    output logic [$clog2(NUM_FRAMES)-1:0] oldest_slot,
    output logic [$clog2(NUM_FRAMES)-1:0] prev_slot,
    output logic cache_full,
    output logic last_cached,
    output logic [DEPTH_W-1:0] spilled
);
    import regfile_pkg::*;
    localparam int SW = $clog2(NUM_FRAMES);
    localparam logic [SW:0] FULL_CNT = (SW + 1)'(NUM_FRAMES);
    localparam logic [SW:0] ONE_CNT = (SW + 1)'(1);

    if (NUM_FRAMES < 2 || (1 << SW) != NUM_FRAMES) begin : g_chk
        $error("frame_tracker: NUM_FRAMES must be a power of two");
    end

    logic [SW:0] cached_reg;

    // Slots form a ring; the oldest sits just ahead of the current one
    always_comb begin
        oldest_slot = cur_slot + SW'(1);
        prev_slot = cur_slot - SW'(1);
        cache_full = (cached_reg == FULL_CNT);
        last_cached = (cached_reg == ONE_CNT);
    end

    // Ring position and depth counts
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cur_slot <= '0;
            cached_reg <= ONE_CNT;
            spilled <= '0;
        end else if (call_commit) begin
            cur_slot <= cur_slot + SW'(1);
            if (cache_full) begin
                spilled <= spilled + DEPTH_W'(1);
            end else begin
                cached_reg <= cached_reg + ONE_CNT;
            end
        end else if (ret_commit) begin
            cur_slot <= cur_slot - SW'(1);
            if (last_cached) begin
                spilled <= spilled - DEPTH_W'(1);
            end else begin
                cached_reg <= cached_reg - ONE_CNT;
            end
        end
    end

    property p_cached_bound;
        @(posedge ref_clk) disable iff (rst)
        cached_reg >= ONE_CNT && cached_reg <= FULL_CNT;
    endproperty
    a_cached_bound: assert property (p_cached_bound)
        else $error("cached frame count out of range");

    property p_spill_count;
        @(posedge ref_clk) disable iff (rst)
        call_commit && cache_full |=> spilled == $past(spilled) + 1'b1
            && cache_full;
    endproperty
    a_spill_count: assert property (p_spill_count)
        else $error("spill did not deepen memory stack");
endmodule

/* design/load_scoreboard.sv */
// Per-register pending-load marks with a cap on outstanding loads
`include "regfile_consts.svh"
module load_scoreboard #(
    parameter int NUM_REGS = 32,
    parameter int MAX_PEND = `MAX_LOADS
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Load start
    input wire logic set_en,
    input wire logic [$clog2(NUM_REGS)-1:0] set_idx,
    // Load completion
    input wire logic clr_en,
    input wire logic [$clog2(NUM_REGS)-1:0] clr_idx,
    // State
    output logic [NUM_REGS-1:0] pend,
    output logic full
);
    import regfile_pkg::*;
    localparam int IW = $clog2(NUM_REGS);

    if (MAX_PEND < 1 || MAX_PEND > NUM_REGS) begin : g_chk
        $error("load_scoreboard: MAX_PEND out of range");
    end

    // One mark per register; a new load beats a completion on the same bit
    for (genvar i = 0; i < NUM_REGS; i++) begin : g_bit
        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                pend[i] <= 1'b0;
            end else if (set_en && set_idx == IW'(i)) begin
                pend[i] <= 1'b1;
            end else if (clr_en && clr_idx == IW'(i)) begin
                pend[i] <= 1'b0;
            end
        end
    end

    // Cap reached; issue logic refuses further loads
    always_comb begin
        full = ($countones(pend) >= MAX_PEND);
    end

    property p_set_marks;
        @(posedge ref_clk) disable iff (rst)
        set_en |=> pend[$past(set_idx)];
    endproperty
    a_set_marks: assert property (p_set_marks)
        else $error("load start did not mark register");

    property p_clr_frees;
        @(posedge ref_clk) disable iff (rst)
        clr_en && !(set_en && set_idx == clr_idx)
            |=> !pend[$past(clr_idx)];
    endproperty
    a_clr_frees: assert property (p_clr_frees)
        else $error("load completion did not clear mark");

    property p_cap;
        @(posedge ref_clk) disable iff (rst)
        $countones(pend) <= MAX_PEND;
    endproperty
    a_cap: assert property (p_cap)
        else $error("more loads pending than allowed");
endmodule

/* design/regfile_consts.svh */
// Constants for the scoreboarded register file and local frame cache
//
// Behaviour
// - Sixteen 32-bit global registers are visible to every procedure.
// - Four 80-bit extended-precision float registers are also global.
// - Each call gets a fresh private set of sixteen 32-bit locals.
// - Up to four local frames stay on chip, so three calls need no memory.
// - A call with four frames active spills the oldest frame to memory.
// - Global register 15 points at the memory stack for spilled frames.
// - Calls and returns leave global and float registers untouched.
// - Starting a load marks its destination register as pending.
// - Writing the returned load data clears that pending mark.
// - An operand read of a pending register holds its instruction.
// - Non-load instructions free of pending registers issue without waiting unless a call or return is in progress.
// - At most three loads are pending at once, one mark each.
// - Any 32-bit register may hold single or double float operands.
// - An ALU result is forwarded to a reader while being written.
`ifndef REGFILE_CONSTS_SVH
`define REGFILE_CONSTS_SVH

`define WORD_W 32
`define EXT_W 80
`define IDX_W 5
`define EXT_IDX_W 2
`define NUM_GLOBAL 16
`define NUM_LOCAL 16
`define NUM_EXT 4
`define NUM_FRAMES 4
`define MAX_LOADS 3
`define GLOBAL_SEL_BIT 4
`define SFP_IDX 4'hF
`define LAST_WORD 4'hF
`define FRAME_BYTES 32'h40
`define WORD_BYTES 32'h4
`define RESET_WORD 32'h0
`define RESET_EXT 80'h0
`define DEPTH_W 16

`endif

/* design/regfile_pkg.sv */
// Shared types for the register file and frame cache
`include "regfile_consts.svh"
package regfile_pkg;
    typedef struct packed {
        logic valid;
        logic use_a;
        logic [`IDX_W-1:0] src_a;
        logic use_b;
        logic [`IDX_W-1:0] src_b;
        logic is_load;
        logic [`IDX_W-1:0] dst;
    } issue_req_type;

    typedef struct packed {
        logic valid;
        logic [`IDX_W-1:0] idx;
        logic [`WORD_W-1:0] data;
    } reg_wr_type;

    typedef struct packed {
        logic valid;
        logic [`EXT_IDX_W-1:0] idx;
        logic [`EXT_W-1:0] data;
    } ext_wr_type;

    typedef struct packed {
        logic valid;
        logic write;
        logic [`WORD_W-1:0] addr;
        logic [`WORD_W-1:0] wdata;
    } mem_req_type;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SPILL,
        ST_FILL,
        ST_DONE
    } frame_state_type;
endpackage

/* design/register_file_cache.sv */
// Register file with local frame cache, spill/fill and load scoreboard
`include "regfile_consts.svh"
module register_file_cache (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Instruction issue, one attempt per valid cycle
    input regfile_pkg::issue_req_type issue_req,
    output logic issue_ack_reg,
    output logic issue_stall_reg,
    output logic [`WORD_W-1:0] opnd_a_reg,
    output logic [`WORD_W-1:0] opnd_b_reg,
    // Result and load-return writes
    input regfile_pkg::reg_wr_type alu_wr,
    input regfile_pkg::reg_wr_type load_ret,
    // Extended float registers
    input regfile_pkg::ext_wr_type ext_wr,
    input wire logic [`EXT_IDX_W-1:0] ext_rd_idx,
    output logic [`EXT_W-1:0] ext_rd_data_reg,
    // Procedure call and return
    input wire logic call_req,
    input wire logic ret_req,
    output logic frame_done_reg,
    output logic frame_busy_reg,
    // Memory stack port
    output regfile_pkg::mem_req_type mem_req_reg,
    input wire logic mem_ack,
    input wire logic [`WORD_W-1:0] mem_rdata
);
    import regfile_pkg::*;
    localparam int NREG = `NUM_GLOBAL + `NUM_LOCAL;
    localparam int SW = $clog2(`NUM_FRAMES);

    // Storage
    logic [`WORD_W-1:0] global_mem [`NUM_GLOBAL];
    logic [`WORD_W-1:0] local_mem [`NUM_FRAMES * `NUM_LOCAL];
    logic [`EXT_W-1:0] ext_mem [`NUM_EXT];

    // Frame and scoreboard state
    frame_state_type state_reg, state_next;
    logic [3:0] word_reg, word_next;
    logic call_commit, ret_commit, cache_full, last_cached;
    logic [SW-1:0] cur_slot, oldest_slot, prev_slot;
    logic [`DEPTH_W-1:0] spilled;
    logic [NREG-1:0] sb_pend;
    logic sb_full, loads_idle;

    // Issue decision
    logic haz_a, haz_b, haz_load, haz_frame, issue_go;
    logic [`WORD_W-1:0] rd_a, rd_b, sfp, alu_data, spill_base, fill_base;

    load_scoreboard #(
        .NUM_REGS(NREG),
        .MAX_PEND(`MAX_LOADS)
    ) u_scoreboard (
        .ref_clk(ref_clk),
        .rst(rst),
        .set_en(issue_go && issue_req.is_load),
        .set_idx(issue_req.dst),
        .clr_en(load_ret.valid),
        .clr_idx(load_ret.idx),
        .pend(sb_pend),
        .full(sb_full)
    );

    frame_tracker #(
        .NUM_FRAMES(`NUM_FRAMES),
        .DEPTH_W(`DEPTH_W)
    ) u_frames (
        .ref_clk(ref_clk),
        .rst(rst),
        .call_commit(call_commit),
        .ret_commit(ret_commit),
        .cur_slot(cur_slot),
        .oldest_slot(oldest_slot),
        .prev_slot(prev_slot),
        .cache_full(cache_full),
        .last_cached(last_cached),
        .spilled(spilled)
    );

    // Operand fetch; a same-cycle ALU result overrides the stored copy.
    // Registers are untyped words, so float operands read the same way.
    function automatic logic [`WORD_W-1:0] fetch(
        input logic [`IDX_W-1:0] idx
    );
        logic [`WORD_W-1:0] val;
        if (alu_wr.valid && alu_wr.idx == idx) begin
            val = alu_wr.data;
        end else if (idx[`GLOBAL_SEL_BIT]) begin
            val = global_mem[idx[3:0]];
        end else begin
            val = local_mem[{cur_slot, idx[3:0]}];
        end
        return val;
    endfunction

    // Hazards: pending sources, load cap, frame change in flight
    always_comb begin
        sfp = global_mem[`SFP_IDX];
        alu_data = alu_wr.data;
        loads_idle = (sb_pend == '0);
        haz_a = issue_req.use_a && sb_pend[issue_req.src_a];
        haz_b = issue_req.use_b && sb_pend[issue_req.src_b];
        haz_load = issue_req.is_load &&
            (sb_full || sb_pend[issue_req.dst]);
        haz_frame = (state_reg != ST_IDLE) || call_req || ret_req;
        issue_go = issue_req.valid &&
            !(haz_a || haz_b || haz_load || haz_frame);
        rd_a = fetch(issue_req.src_a);
        rd_b = fetch(issue_req.src_b);
        spill_base = sfp + `WORD_W'(spilled) * `FRAME_BYTES;
        fill_base = sfp + (`WORD_W'(spilled) - 32'h1) * `FRAME_BYTES;
    end

    // Issue answer, one cycle after the attempt
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            issue_ack_reg <= 1'b0;
            issue_stall_reg <= 1'b0;
            opnd_a_reg <= `RESET_WORD;
            opnd_b_reg <= `RESET_WORD;
        end else begin
            issue_ack_reg <= issue_go;
            issue_stall_reg <= issue_req.valid && !issue_go;
            if (issue_go) begin
                opnd_a_reg <= rd_a;
                opnd_b_reg <= rd_b;
            end
        end
    end

    // Frame changes wait for all loads, since a pending local would
    // otherwise land in the wrong frame
    always_comb begin
        state_next = state_reg;
        word_next = word_reg;
        call_commit = 1'b0;
        ret_commit = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                word_next = 4'h0;
                if (call_req && loads_idle) begin
                    if (cache_full) begin
                        state_next = ST_SPILL;
                    end else begin
                        call_commit = 1'b1;
                        state_next = ST_DONE;
                    end
                end else if (ret_req && loads_idle) begin
                    if (last_cached && spilled != '0) begin
                        state_next = ST_FILL;
                    end else begin
                        // Return from the outermost frame is a no-op
                        ret_commit = !last_cached;
                        state_next = ST_DONE;
                    end
                end
            end
            ST_SPILL: begin
                if (mem_ack) begin
                    word_next = word_reg + 4'h1;
                    if (word_reg == `LAST_WORD) begin
                        call_commit = 1'b1;
                        state_next = ST_DONE;
                    end
                end
            end
            ST_FILL: begin
                if (mem_ack) begin
                    word_next = word_reg + 4'h1;
                    if (word_reg == `LAST_WORD) begin
                        ret_commit = 1'b1;
                        state_next = ST_DONE;
                    end
                end
            end
            ST_DONE: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // Frame sequencer state
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            word_reg <= 4'h0;
            frame_done_reg <= 1'b0;
            frame_busy_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            word_reg <= word_next;
            frame_done_reg <= (state_next == ST_DONE);
            frame_busy_reg <= (state_next != ST_IDLE);
        end
    end

    // Memory request held until acknowledged; address steps one word
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mem_req_reg <= '0;
        end else begin
            mem_req_reg.valid <= (state_next == ST_SPILL) ||
                (state_next == ST_FILL);
            mem_req_reg.write <= (state_next == ST_SPILL);
            mem_req_reg.addr <= ((state_next == ST_FILL) ?
                fill_base : spill_base) +
                `WORD_W'(word_next) * `WORD_BYTES;
            mem_req_reg.wdata <= local_mem[{oldest_slot, word_next}];
        end
    end

    // Globals change only by instruction writes, never by call or
    // return; the ALU wins a same-cycle clash with a load return
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < `NUM_GLOBAL; i++) begin
                global_mem[i] <= `RESET_WORD;
            end
        end else if (alu_wr.valid && alu_wr.idx[`GLOBAL_SEL_BIT]) begin
            global_mem[alu_wr.idx[3:0]] <= alu_wr.data;
        end else if (load_ret.valid &&
                     load_ret.idx[`GLOBAL_SEL_BIT]) begin
            global_mem[load_ret.idx[3:0]] <= load_ret.data;
        end
    end

    // Locals: fresh frame on call, fill from memory, instruction writes
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < `NUM_FRAMES * `NUM_LOCAL; i++) begin
                local_mem[i] <= `RESET_WORD;
            end
        end else begin
            if (alu_wr.valid && !alu_wr.idx[`GLOBAL_SEL_BIT]) begin
                local_mem[{cur_slot, alu_wr.idx[3:0]}] <= alu_wr.data;
            end else if (load_ret.valid &&
                         !load_ret.idx[`GLOBAL_SEL_BIT]) begin
                local_mem[{cur_slot, load_ret.idx[3:0]}] <=
                    load_ret.data;
            end
            if (state_reg == ST_FILL && mem_ack) begin
                local_mem[{prev_slot, word_reg}] <= mem_rdata;
            end
            if (call_commit) begin
                for (int i = 0; i < `NUM_LOCAL; i++) begin
                    local_mem[{oldest_slot, 4'(i)}] <= `RESET_WORD;
                end
            end
        end
    end

    // Extended float registers, untouched by frame changes
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < `NUM_EXT; i++) begin
                ext_mem[i] <= `RESET_EXT;
            end
            ext_rd_data_reg <= `RESET_EXT;
        end else begin
            if (ext_wr.valid) begin
                ext_mem[ext_wr.idx] <= ext_wr.data;
            end
            ext_rd_data_reg <= ext_mem[ext_rd_idx];
        end
    end

    sequence s_call_full;
        state_reg == ST_IDLE && call_req && loads_idle && cache_full;
    endsequence
    sequence s_ret_fill;
        state_reg == ST_IDLE && !call_req && ret_req && loads_idle &&
            last_cached && spilled != '0;
    endsequence
    property p_spill_start;
        @(posedge ref_clk) disable iff (rst)
        s_call_full |=> mem_req_reg.valid && mem_req_reg.write &&
            mem_req_reg.addr == $past(spill_base) && frame_busy_reg;
    endproperty
    a_spill_start: assert property (p_spill_start)
        else $error("full cache call did not spill");
    property p_fill_start;
        @(posedge ref_clk) disable iff (rst)
        s_ret_fill |=> mem_req_reg.valid && !mem_req_reg.write &&
            !frame_done_reg;
    endproperty
    a_fill_start: assert property (p_fill_start)
        else $error("return to spilled frame did not reload");
    property p_call_fast;
        @(posedge ref_clk) disable iff (rst)
        state_reg == ST_IDLE && call_req && loads_idle && !cache_full
            |=> frame_done_reg && !mem_req_reg.valid;
    endproperty
    a_call_fast: assert property (p_call_fast)
        else $error("cached call touched memory or was late");
    property p_stall_pending;
        @(posedge ref_clk) disable iff (rst)
        issue_req.valid && issue_req.use_a && sb_pend[issue_req.src_a]
            |=> issue_stall_reg && !issue_ack_reg;
    endproperty
    a_stall_pending: assert property (p_stall_pending)
        else $error("read of pending register not held");
    property p_no_wait;
        @(posedge ref_clk) disable iff (rst)
        issue_req.valid && !issue_req.is_load && !haz_a && !haz_b &&
            state_reg == ST_IDLE && !call_req && !ret_req
            |=> issue_ack_reg;
    endproperty
    a_no_wait: assert property (p_no_wait)
        else $error("independent instruction was held");
    property p_load_cap;
        @(posedge ref_clk) disable iff (rst)
        issue_req.valid && issue_req.is_load && sb_full
            |=> !issue_ack_reg && issue_stall_reg;
    endproperty
    a_load_cap: assert property (p_load_cap)
        else $error("fourth load was accepted");
    property p_bypass;
        @(posedge ref_clk) disable iff (rst)
        issue_go && issue_req.use_a && alu_wr.valid &&
            alu_wr.idx == issue_req.src_a
            |=> opnd_a_reg == $past(alu_data);
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("ALU result not forwarded");
    property p_sfp_kept;
        @(posedge ref_clk) disable iff (rst)
        (call_commit || ret_commit) && !alu_wr.valid && !load_ret.valid
            |=> $stable(sfp);
    endproperty
    a_sfp_kept: assert property (p_sfp_kept)
        else $error("frame change altered a global");
endmodule

/* tb/register_file_cache_test.sv */
// Scenario testbench for the register file with frame cache
module register_file_cache_test;
    timeunit 1ns;
    timeprecision 1ns;
    import regfile_pkg::*;
    logic ref_clk, rst, call_req, ret_req, mem_ack, slow;
    issue_req_type issue_req;
    reg_wr_type alu_wr, load_ret;
    ext_wr_type ext_wr;
    mem_req_type mem_req_reg;
    logic [1:0] ext_rd_idx;
    logic [79:0] ext_rd_data_reg;
    logic [31:0] opnd_a_reg, opnd_b_reg, mem_rdata;
    logic issue_ack_reg, issue_stall_reg, frame_done_reg, frame_busy_reg;
    int fails, total_checks;

    register_file_cache u_register_file_cache (.ref_clk(ref_clk),
        .rst(rst), .issue_req(issue_req), .issue_ack_reg(issue_ack_reg),
        .issue_stall_reg(issue_stall_reg), .opnd_a_reg(opnd_a_reg),
        .opnd_b_reg(opnd_b_reg), .alu_wr(alu_wr), .load_ret(load_ret),
        .ext_wr(ext_wr), .ext_rd_idx(ext_rd_idx),
        .ext_rd_data_reg(ext_rd_data_reg), .call_req(call_req),
        .ret_req(ret_req), .frame_done_reg(frame_done_reg),
        .frame_busy_reg(frame_busy_reg), .mem_req_reg(mem_req_reg),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    stack_mem_model u_stack_mem_model (.ref_clk(ref_clk),
        .mem_req(mem_req_reg), .slow(slow), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata));

    // Free-running 50 MHz clock
    always #10 ref_clk = ~ref_clk;

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string what, input logic [79:0] exp,
                       input logic [79:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One issue attempt; answer is judged the cycle after it is taken
    task automatic iss(input logic ua, input logic [4:0] src,
                       input logic ld, input logic [4:0] dst, input logic ok);
        @(posedge ref_clk);
        issue_req <= '{1'h1, ua, src, 1'h0, 5'h0, ld, dst};
        @(posedge ref_clk);
        issue_req.valid <= 1'h0;
        #1;
        chk("issue ack", ok, issue_ack_reg);
        chk("issue stall", !ok, issue_stall_reg);
    endtask

    task automatic rd(input logic [4:0] idx, input logic [31:0] exp);
        iss(1'h1, idx, 1'h0, 5'h0, 1'h1);
        chk("operand", exp, opnd_a_reg);
    endtask

    task automatic wr(input logic [4:0] idx, input logic [31:0] d);
        @(posedge ref_clk);
        alu_wr <= '{1'h1, idx, d};
        @(posedge ref_clk);
        alu_wr.valid <= 1'h0;
    endtask

    task automatic ldr(input logic [4:0] idx, input logic [31:0] d);
        @(posedge ref_clk);
        load_ret <= '{1'h1, idx, d};
        @(posedge ref_clk);
        load_ret.valid <= 1'h0;
    endtask

    // Request held until the done pulse is seen, dropped at the next edge
    task automatic frame(input logic call, input logic spill);
        int n;
        n = 0;
        @(posedge ref_clk);
        call_req <= call;
        ret_req <= !call;
        do begin
            @(posedge ref_clk);
            #1;
            n++;
        end while (frame_done_reg !== 1'h1 && n < 200);
        if (n >= 200) begin
            fails++;
            wrap_up();
        end
        chk("frame busy", 1'h1, frame_busy_reg);
        chk("frame cycles ok", 1'h1, spill ? n > 16 : n == 1);
        @(posedge ref_clk);
        call_req <= 1'h0;
        ret_req <= 1'h0;
    endtask

    task automatic t_regs;
        chk("busy after reset", 1'h0, frame_busy_reg);
        wr(5'h13, 32'h12345678);
        rd(5'h13, 32'h12345678);
        @(posedge ref_clk);
        alu_wr <= '{1'h1, 5'h14, 32'hCAFE0001};
        issue_req <= '{1'h1, 1'h1, 5'h14, 1'h1, 5'h13, 1'h0, 5'h0};
        @(posedge ref_clk);
        alu_wr.valid <= 1'h0;
        issue_req.valid <= 1'h0;
        #1;
        chk("bypass operand", 32'hCAFE0001, opnd_a_reg);
        chk("operand b", 32'h12345678, opnd_b_reg);
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk);
            ext_wr <= '{1'h1, i[1:0], 80'hABCD0000000000000000 + 80'(i)};
        end
        @(posedge ref_clk);
        ext_wr.valid <= 1'h0;
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk);
            ext_rd_idx <= i[1:0];
            @(posedge ref_clk);
            #1;
            chk("ext", {16'hABCD, 64'(i)}, ext_rd_data_reg);
        end
        $display("test regs done");
    endtask

    task automatic t_loads;
        iss(1'h0, 5'h0, 1'h1, 5'h1, 1'h1);
        iss(1'h0, 5'h0, 1'h1, 5'h2, 1'h1);
        iss(1'h0, 5'h0, 1'h1, 5'h3, 1'h1);
        iss(1'h0, 5'h0, 1'h1, 5'h4, 1'h0);
        iss(1'h1, 5'h13, 1'h0, 5'h0, 1'h1);
        iss(1'h1, 5'h1, 1'h0, 5'h0, 1'h0);
        @(posedge ref_clk);
        issue_req <= '{1'h1, 1'h0, 5'h0, 1'h1, 5'h2, 1'h0, 5'h0};
        @(posedge ref_clk);
        issue_req.valid <= 1'h0;
        #1;
        chk("b stall", 1'h1, issue_stall_reg);
        ldr(5'h1, 32'h11);
        rd(5'h1, 32'h11);
        iss(1'h0, 5'h0, 1'h1, 5'h4, 1'h1);
        ldr(5'h2, 32'h22);
        ldr(5'h3, 32'h33);
        ldr(5'h4, 32'h44);
        rd(5'h4, 32'h44);
        $display("test loads done");
    endtask

    task automatic t_frames;
        wr(5'h1F, 32'h100);
        wr(5'h0, 32'hA0);
        frame(1'h1, 1'h0);
        rd(5'h0, 32'h0);
        frame(1'h1, 1'h0);
        frame(1'h1, 1'h0);
        slow <= 1'h1;
        frame(1'h1, 1'h1);
        chk("spilled word", 32'hA0, u_stack_mem_model.mem[64]);
        rd(5'h13, 32'h12345678);
        rd(5'h1F, 32'h100);
        for (int i = 0; i < 3; i++)
            frame(1'h0, 1'h0);
        frame(1'h0, 1'h1);
        rd(5'h0, 32'hA0);
        $display("test frames done");
    endtask

    // Reset for six cycles, then the scenarios in turn
    initial begin
        ref_clk = 1'h0;
        rst = 1'h1;
        call_req = 1'h0;
        ret_req = 1'h0;
        slow = 1'h0;
        issue_req = '0;
        alu_wr = '0;
        load_ret = '0;
        ext_wr = '0;
        ext_rd_idx = 2'h0;
        fails = 0;
        total_checks = 0;
        repeat (6) @(posedge ref_clk);
        rst <= 1'h0;
        t_regs();
        t_loads();
        t_frames();
        wrap_up();
    end
endmodule

/* tb/stack_mem_model.sv */
// Behavioural memory stack for the register file spill and fill port
module stack_mem_model (
    // Clock
    input wire logic ref_clk,
    // Request side
    input regfile_pkg::mem_req_type mem_req,
    input wire logic slow,
    // Answer side
    output logic mem_ack,
    output logic [31:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] mem [0:255];
    logic gap;
    logic go;
    initial begin
        mem_ack = 1'h0;
        mem_rdata = 32'h0;
        gap = 1'h0;
    end
    // Slow mode waits every other cycle before taking a word
    assign go = mem_req.valid && !mem_ack && (!slow || gap);
    // Data toggles between words so stale values never pass
    always @(posedge ref_clk) begin
        gap <= ~gap;
        mem_ack <= go;
        mem_rdata <= ~mem_rdata;
        if (go && !mem_req.write)
            mem_rdata <= mem[mem_req.addr[9:2]];
        if (mem_req.valid && mem_ack && mem_req.write)
            mem[mem_req.addr[9:2]] <= mem_req.wdata;
    end
endmodule
